/* File: common/spfpu_params.svh */
// Constants of the single precision floating point unit
`ifndef SPFPU_PARAMS_SVH
`define SPFPU_PARAMS_SVH

`define SPFPU_EXP_ALL1 8'hff
`define SPFPU_BIAS 12'h07f
`define SPFPU_QNAN 32'hffc00000
`define SPFPU_INF_MAG 31'h7f800000
`define SPFPU_INT_MAX 32'h7fffffff
`define SPFPU_INT_MIN 32'h80000000
`define SPFPU_FINT_MIN_WORD 32'hcf000000
`define SPFPU_CVT_EXP 12'h09d
`define SPFPU_FINT_ONE_EXP 8'h7f
`define SPFPU_FINT_EXACT_EXP 8'h96
`define SPFPU_FINT_LIM_EXP 8'h9e
`define SPFPU_ADD_WIDTH 8'h32
`define SPFPU_CFG_EXTENDED 2
`define SPFPU_ITER_STEPS 27
`define SPFPU_DIV_LATENCY 30
`define SPFPU_SIMPLE_LATENCY 2

`define SPFPU_REG_CTRL 4'h0
`define SPFPU_FLOAT_STATUS_REGISTER 4'h4
`define SPFPU_REG_MASK 4'h8
`define SPFPU_CTRL_EXC_EN 0
`define SPFPU_STAT_BUSY 8
`define SPFPU_FLG_W 5
`define SPFPU_FLG_UNF 0
`define SPFPU_FLG_OVF 1
`define SPFPU_FLG_DZ 2
`define SPFPU_FLG_INV 3
`define SPFPU_FLG_DEN 4
`define SPFPU_FLG_RST 5'h00
`define SPFPU_MASK_RST 5'h00
`define SPFPU_CTRL_RST 1'b0

`endif

/* File: common/spfpu_pkg.sv */
// Types shared by the floating point unit files
package spfpu_pkg;

  typedef enum logic [3:0] {
    op_add = 4'h0,
    op_sub = 4'h1,
    op_mul = 4'h2,
    op_div = 4'h3,
    compare_less_op = 4'h4,
    compare_equal_op = 4'h5,
    compare_less_equal_op = 4'h6,
    compare_greater_op = 4'h7,
    compare_not_equal_op = 4'h8,
    compare_greater_equal_op = 4'h9,
    compare_unordered_op = 4'ha,
    op_sqrt = 4'hb,
    op_flt = 4'hc,
    op_fint = 4'hd
  } spfpu_op_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_exec = 3'b010,
    st_wait = 3'b100
  } spfpu_state_t;

  typedef struct packed {
    logic den;
    logic nan;
    logic snan;
    logic inf;
    logic zero;
  } spfpu_cls_t;

endpackage

/* File: rtl/spfpu_pack.sv */
// Normalise, round to nearest even and pack a raw result
`timescale 1ns/1ps
`include "spfpu_params.svh"

module spfpu_pack import spfpu_pkg::*; (
  input wire logic sign,
  input wire logic signed [11:0] exp_in,
  input wire logic [49:0] raw,
  output logic [31:0] word,
  output logic ovf,
  output logic unf
);

  // Raw value is raw / 2**48 * 2**(exp_in - bias)
  function automatic logic [5:0] lead_one(input logic [49:0] v);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 50; i++) begin
      if (v[i]) p = 6'(i);
    end
    return p;
  endfunction

  logic [5:0] p;
  logic [49:0] sh;
  logic signed [11:0] e;
  logic [24:0] man;
  logic guard;
  logic sticky;

  always_comb begin
    p = lead_one(raw);
    sh = raw << (6'h31 - p);
    e = exp_in + signed'({6'h00, p}) - 12'sh030;
    man = {1'b0, sh[49:26]};
    guard = sh[25];
    sticky = |sh[24:0];
    ovf = 1'b0;
    unf = 1'b0;
    if (guard && (sticky || man[0])) begin
      man = man + 25'h1;
    end
    if (man[24]) begin
      man = man >> 1;
      e = e + 12'sh001;
    end
    if (raw == 50'h0) begin
      word = {sign, 31'h0};
    end else if (e >= 12'sh0ff) begin
      word = {sign, `SPFPU_INF_MAG};
      ovf = 1'b1;
    end else if (e <= 12'sh000) begin
      word = {sign, 31'h0};
      unf = 1'b1;
    end else begin
      word = {sign, e[7:0], man[22:0]};
    end
  end

endmodule // spfpu_pack

/* File: rtl/spfpu_iter.sv */
// Serial restoring divider and square root, one result bit per cycle
`timescale 1ns/1ps
`include "spfpu_params.svh"

module spfpu_iter import spfpu_pkg::*; #(
  parameter int steps = `SPFPU_ITER_STEPS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic sqrt_mode,
  input wire logic [53:0] rad,
  input wire logic [23:0] den,
  output logic done,
  output logic [26:0] root,
  output logic sticky
);

  logic run_q, mode_q, done_q;
  logic [4:0] cnt_q;
  logic [29:0] rem_q;
  logic [53:0] rad_q;
  logic [26:0] res_q;
  logic [23:0] den_q;
  logic [29:0] cur, trial, nrem;
  logic ge;

  always_comb begin
    cur = mode_q ? {rem_q[27:0], rad_q[53:52]} : rem_q;
    trial = mode_q ? {1'b0, res_q, 2'b01} : {6'h00, den_q};
    ge = cur >= trial;
    nrem = ge ? cur - trial : cur;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      mode_q <= 1'b0;
      cnt_q <= 5'h00;
      rem_q <= 30'h0;
      rad_q <= 54'h0;
      res_q <= 27'h0;
      den_q <= 24'h0;
    end else if (start) begin
      run_q <= 1'b1;
      mode_q <= sqrt_mode;
      cnt_q <= 5'(steps - 1);
      rem_q <= sqrt_mode ? 30'h0 : {6'h00, rad[23:0]};
      rad_q <= rad;
      res_q <= 27'h0;
      den_q <= den;
    end else if (run_q) begin
      rem_q <= mode_q ? nrem : {nrem[28:0], 1'b0};
      rad_q <= {rad_q[51:0], 2'b00};
      res_q <= {res_q[25:0], ge};
      cnt_q <= cnt_q - 5'h01;
      if (cnt_q == 5'h00) run_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) done_q <= 1'b0;
    else done_q <= run_q && (cnt_q == 5'h00);
  end

  assign done = done_q;
  assign root = res_q;
  assign sticky = rem_q != 30'h0;

endmodule // spfpu_iter

/* File: rtl/spfpu_top.sv */
// Single precision floating point unit: sequencer, datapath and registers
`timescale 1ns/1ps
`include "spfpu_params.svh"
////////////////////////////////////////////////////////////////////////////
// Contract
// - Words are sign, 8-bit exponent, 23-bit fraction
// - Exponent 255, nonzero fraction means not-a-number
// - Exponent 255, zero fraction means signed infinity
// - Normal value is 1.fraction times 2**(exp-127)
// - Zero exponent and fraction is signed zero
// - Round to nearest, ties to even
// - Operands and results use processor general registers
// - Add, sub, mul, div; square root only extended
// - Seven comparisons including unordered for NaN
// - Integer conversions only in extended configuration
// - Enabled exceptions raise processor hardware exception
// - Exception suppresses the destination register write
// - One operation at a time, no pipelining
// - Single precision only, double left to software
// - Denormal operand gives quiet NaN, sticky flag
// - Denormal result flushed to signed zero, underflow
// - NaN operand returns fixed NaN pattern, except comparisons return 0 or 1
// - Overflow returns infinity with true sign
////////////////////////////////////////////////////////////////////////////

module spfpu_top import spfpu_pkg::*; #(
  parameter int unit_configuration_param = `SPFPU_CFG_EXTENDED
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [31:0] OP_A,
  input wire logic [31:0] OP_B,
  input wire logic [4:0] OP_DEST,
  output logic BUSY,
  output logic RES_VALID,
  output logic RES_WE,
  output logic [4:0] RES_DEST,
  output logic [31:0] RES_DATA,
  output logic FP_EXC,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ
);

  function automatic spfpu_cls_t classify(input logic [31:0] x);
    spfpu_cls_t c;
    c.zero = x[30:0] == 31'h0;
    c.den = (x[30:23] == 8'h00) && (x[22:0] != 23'h0);
    c.inf = (x[30:23] == `SPFPU_EXP_ALL1) && (x[22:0] == 23'h0);
    c.nan = (x[30:23] == `SPFPU_EXP_ALL1) && (x[22:0] != 23'h0);
    c.snan = c.nan && !x[22];
    return c;
  endfunction

  // Maps a word onto an unsigned key in numeric order, both zeros equal
  function automatic logic [31:0] order_key(input logic [31:0] x);
    if (x[30:0] == 31'h0) return `SPFPU_INT_MIN;
    else if (x[31]) return ~x;
    else return {1'b1, x[30:0]};
  endfunction

  function automatic logic [49:0] shr_sticky(input logic [49:0] v,
                                             input logic [7:0] amt);
    logic [49:0] lost;
    lost = v & ((50'h1 << amt) - 50'h1);
    if (amt >= `SPFPU_ADD_WIDTH) return {49'h0, |v};
    return (v >> amt) | {49'h0, |lost};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operation latch and sequencer

  spfpu_state_t state_q;
  spfpu_op_t op_q;
  logic [31:0] a_q, b_q;
  logic [4:0] dest_q;
  logic rsign_q;
  logic signed [11:0] rexp_q;
  logic busy_q, res_valid_q, res_we_q, fp_exc_q, irq_q;
  logic [31:0] res_data_q, rdata_q;
  logic [4:0] res_dest_q;
  logic exc_en_q;
  logic [4:0] mask_q, float_status_register_q, status_d;

  spfpu_cls_t cls_a, cls_b;
  logic sa, sb, uses_b, is_ext, bad_den, any_nan, any_snan, big;
  logic lt, eq, unord;
  logic [7:0] ea, eb, d;
  logic [23:0] ma, mb;
  logic [47:0] prod;
  logic [49:0] xs, raw;
  logic [31:0] mag;
  logic signed [11:0] rexp, half;
  logic rsign, spec, need_iter;
  logic [31:0] spec_word;
  logic [4:0] spec_flags;
  logic [53:0] iter_rad;
  logic iter_start, iter_done, iter_sticky;
  logic [26:0] iter_root;
  logic pk_sign, pk_ovf, pk_unf;
  logic signed [11:0] pk_exp;
  logic [49:0] pk_raw;
  logic [31:0] pk_word, fin_word;
  logic [4:0] fin_flags;
  logic finish, take, exc;

  // New work is taken only from idle, so nothing overlaps
  assign take = (state_q == st_idle) && OP_VALID;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= st_idle;
    end else begin
      case (state_q)
        st_idle: if (take) state_q <= st_exec;
        st_exec: state_q <= need_iter ? st_wait : st_idle;
        st_wait: if (iter_done) state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // Operands come from and results go to the general registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      op_q <= op_add;
      a_q <= 32'h0;
      b_q <= 32'h0;
      dest_q <= 5'h00;
    end else if (take) begin
      op_q <= spfpu_op_t'(OP_CODE);
      a_q <= OP_A;
      b_q <= OP_B;
      dest_q <= OP_DEST;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsign_q <= 1'b0;
      rexp_q <= 12'sh000;
    end else if (iter_start) begin
      rsign_q <= rsign;
      rexp_q <= rexp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath: special cases and raw results

  always_comb begin
    cls_a = classify(a_q);
    cls_b = classify(b_q);
    sa = a_q[31];
    sb = (op_q == op_sub) ? ~b_q[31] : b_q[31];
    ea = a_q[30:23];
    eb = b_q[30:23];
    ma = {|ea, a_q[22:0]};
    mb = {|eb, b_q[22:0]};
    is_ext = op_q inside {op_sqrt, op_flt, op_fint};
    uses_b = !is_ext;
    bad_den = (op_q != op_flt) && (cls_a.den || (uses_b && cls_b.den));
    any_nan = (op_q != op_flt) && (cls_a.nan || (uses_b && cls_b.nan));
    any_snan = (op_q != op_flt) && (cls_a.snan || (uses_b && cls_b.snan));
    unord = cls_a.nan || cls_b.nan;
    lt = order_key(a_q) < order_key(b_q);
    eq = order_key(a_q) == order_key(b_q);
    big = {ea, ma} >= {eb, mb};
    d = big ? ea - eb : eb - ea;
    xs = big ? {1'b0, ma, 25'h0} : {1'b0, mb, 25'h0};
    prod = {24'h0, ma} * {24'h0, mb};
    mag = 32'h0;
    half = 12'sh000;
    spec = 1'b1;
    spec_word = `SPFPU_QNAN;
    spec_flags = 5'h00;
    need_iter = 1'b0;
    raw = 50'h0;
    rsign = sa ^ b_q[31];
    rexp = 12'sh000;
    iter_rad = 54'h0;
    // Every opcode is single precision; there is no wider format
    if (is_ext && unit_configuration_param != `SPFPU_CFG_EXTENDED) begin
      spec_flags[`SPFPU_FLG_INV] = 1'b1;
    end else if (bad_den) begin
      spec_flags[`SPFPU_FLG_DEN] = 1'b1;
    end else if (op_q inside {[compare_less_op:compare_unordered_op]}) begin
      spec_flags[`SPFPU_FLG_INV] = any_snan;
      case (op_q)
        compare_less_op: spec_word = {31'h0, !unord && lt};
        compare_equal_op: spec_word = {31'h0, !unord && eq};
        compare_less_equal_op: spec_word = {31'h0, !unord && (lt || eq)};
        compare_greater_op: spec_word = {31'h0, !unord && !lt && !eq};
        compare_not_equal_op: spec_word = {31'h0, unord || !eq};
        compare_greater_equal_op: spec_word = {31'h0, !unord && !lt};
        default: spec_word = {31'h0, unord};
      endcase
    end else if (any_nan) begin
      spec_flags[`SPFPU_FLG_INV] = any_snan;
    end else begin
      case (op_q)
        op_add, op_sub: begin
          if (cls_a.inf && cls_b.inf && sa != sb) begin
            spec_flags[`SPFPU_FLG_INV] = 1'b1;
          end else if (cls_a.inf) begin
            spec_word = {sa, `SPFPU_INF_MAG};
          end else if (cls_b.inf) begin
            spec_word = {sb, `SPFPU_INF_MAG};
          end else begin
            spec = 1'b0;
            raw = shr_sticky(big ? {1'b0, mb, 25'h0} : {1'b0, ma, 25'h0}, d);
            raw = (sa == sb) ? xs + raw : xs - raw;
            rsign = big ? sa : sb;
            if (raw == 50'h0 && sa != sb) rsign = 1'b0;
            rexp = big ? {4'h0, ea} : {4'h0, eb};
          end
        end
        op_mul: begin
          if ((cls_a.zero && cls_b.inf) || (cls_a.inf && cls_b.zero)) begin
            spec_flags[`SPFPU_FLG_INV] = 1'b1;
          end else if (cls_a.inf || cls_b.inf) begin
            spec_word = {rsign, `SPFPU_INF_MAG};
          end else begin
            spec = 1'b0;
            raw = {prod, 2'b00};
            rexp = {4'h0, ea} + {4'h0, eb} - `SPFPU_BIAS;
          end
        end
        op_div: begin
          if ((cls_a.zero && cls_b.zero) || (cls_a.inf && cls_b.inf)) begin
            spec_flags[`SPFPU_FLG_INV] = 1'b1;
          end else if (cls_a.inf) begin
            spec_word = {rsign, `SPFPU_INF_MAG};
          end else if (cls_b.zero) begin
            spec_word = {rsign, `SPFPU_INF_MAG};
            spec_flags[`SPFPU_FLG_DZ] = 1'b1;
          end else if (cls_a.zero || cls_b.inf) begin
            spec_word = {rsign, 31'h0};
          end else begin
            spec = 1'b0;
            need_iter = 1'b1;
            iter_rad = {30'h0, ma};
            rexp = {4'h0, ea} - {4'h0, eb} + `SPFPU_BIAS;
          end
        end
        op_sqrt: begin
          if (cls_a.zero) begin
            spec_word = a_q;
          end else if (sa) begin
            spec_flags[`SPFPU_FLG_INV] = 1'b1;
          end else if (cls_a.inf) begin
            spec_word = a_q;
          end else begin
            spec = 1'b0;
            need_iter = 1'b1;
            rsign = 1'b0;
            // Odd unbiased exponent doubles the radicand to keep it even
            iter_rad = ea[0] ? {1'b0, ma, 29'h0} : {ma, 30'h0};
            half = {4'h0, ea} - `SPFPU_BIAS - {11'h0, ~ea[0]};
            // Keep the sum signed so a negative half exponent shifts in ones
            rexp = (half >>> 1) + signed'(`SPFPU_BIAS);
          end
        end
        op_flt: begin
          spec = 1'b0;
          rsign = a_q[31];
          mag = a_q[31] ? 32'h0 - a_q : a_q;
          raw = {mag, 18'h0};
          rexp = `SPFPU_CVT_EXP;
        end
        op_fint: begin
          // Conversion truncates toward zero, as C casts expect
          if (ea < `SPFPU_FINT_ONE_EXP) begin
            spec_word = 32'h0;
          end else if (a_q == `SPFPU_FINT_MIN_WORD) begin
            spec_word = `SPFPU_INT_MIN;
          end else if (ea >= `SPFPU_FINT_LIM_EXP) begin
            spec_word = sa ? `SPFPU_INT_MIN : `SPFPU_INT_MAX;
            spec_flags[`SPFPU_FLG_INV] = 1'b1;
          end else begin
            mag = (ea >= `SPFPU_FINT_EXACT_EXP)
              ? {8'h0, ma} << (ea - `SPFPU_FINT_EXACT_EXP)
              : {8'h0, ma} >> (`SPFPU_FINT_EXACT_EXP - ea);
            spec_word = sa ? 32'h0 - mag : mag;
          end
        end
        default: spec_flags[`SPFPU_FLG_INV] = 1'b1;
      endcase
    end
  end

  assign iter_start = (state_q == st_exec) && need_iter;

  spfpu_iter #(.steps(`SPFPU_ITER_STEPS)) u_iter (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .start(iter_start),
    .sqrt_mode(op_q == op_sqrt),
    .rad(iter_rad),
    .den(mb),
    .done(iter_done),
    .root(iter_root),
    .sticky(iter_sticky)
  );

  always_comb begin
    pk_sign = (state_q == st_wait) ? rsign_q : rsign;
    pk_exp = (state_q == st_wait) ? rexp_q : rexp;
    pk_raw = (state_q == st_wait)
      ? {1'b0, iter_root, iter_sticky, 21'h0} : raw;
  end

  spfpu_pack u_pack (
    .sign(pk_sign),
    .exp_in(pk_exp),
    .raw(pk_raw),
    .word(pk_word),
    .ovf(pk_ovf),
    .unf(pk_unf)
  );

  always_comb begin
    finish = ((state_q == st_exec) && !need_iter) ||
             ((state_q == st_wait) && iter_done);
    fin_word = ((state_q == st_exec) && spec) ? spec_word : pk_word;
    fin_flags = ((state_q == st_exec) && spec)
      ? spec_flags : {3'h0, pk_ovf, pk_unf};
    exc = exc_en_q && (fin_flags != 5'h00);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result port

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_q <= 1'b0;
    end else if (take) begin
      busy_q <= 1'b1;
    end else if (finish) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      res_valid_q <= 1'b0;
      res_we_q <= 1'b0;
      fp_exc_q <= 1'b0;
      res_data_q <= 32'h0;
      res_dest_q <= 5'h00;
    end else begin
      res_valid_q <= finish;
      res_we_q <= finish && !exc;
      fp_exc_q <= finish && exc;
      if (finish) begin
        res_data_q <= fin_word;
        res_dest_q <= dest_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt

  // A flag raised in the clearing read cycle survives the clear
  always_comb begin
    status_d = float_status_register_q;
    if (REG_RD && REG_ADDR == `SPFPU_FLOAT_STATUS_REGISTER) status_d = 5'h00;
    if (finish) status_d = status_d | fin_flags;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) float_status_register_q <= `SPFPU_FLG_RST;
    else float_status_register_q <= status_d;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      exc_en_q <= `SPFPU_CTRL_RST;
      mask_q <= `SPFPU_MASK_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == `SPFPU_REG_CTRL) begin
        exc_en_q <= REG_WDATA[`SPFPU_CTRL_EXC_EN];
      end
      if (REG_ADDR == `SPFPU_REG_MASK) mask_q <= REG_WDATA[4:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `SPFPU_REG_CTRL: rdata_q <= {31'h0, exc_en_q};
        `SPFPU_FLOAT_STATUS_REGISTER:
          rdata_q <= {23'h0, busy_q, 3'h0, float_status_register_q};
        `SPFPU_REG_MASK: rdata_q <= {27'h0, mask_q};
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) irq_q <= 1'b0;
    else irq_q <= |(float_status_register_q & mask_q);
  end

  assign BUSY = busy_q;
  assign RES_VALID = res_valid_q;
  assign RES_WE = res_we_q;
  assign RES_DEST = res_dest_q;
  assign RES_DATA = res_data_q;
  assign FP_EXC = fp_exc_q;
  assign REG_RDATA = rdata_q;
  assign IRQ = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking dflt_clk @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_taken;
    (state_q == st_idle) && OP_VALID;
  endsequence

  sequence s_short_op;
    (state_q == st_exec) && !need_iter;
  endsequence

  a_one_at_a_time: assert property (
    s_taken |=> BUSY && state_q == st_exec)
    else $error("operation not taken into a busy execute state");
  a_short_finish: assert property (
    s_short_op |=> RES_VALID && !BUSY)
    else $error("short operation did not finish after one cycle");
  a_iter_busy: assert property (
    iter_start |=> BUSY[*8])
    else $error("busy dropped during iterative operation");
  a_iter_latency: assert property (
    iter_start |-> ##29 RES_VALID)
    else $error("divide or square root latency wrong");
  a_exc_no_write: assert property (
    FP_EXC |-> RES_VALID && !RES_WE)
    else $error("result written despite exception");
  a_exc_cause: assert property (
    FP_EXC |-> $past(exc_en_q) && float_status_register_q != 5'h00)
    else $error("exception without enabled flag");
  a_den_nan: assert property (
    finish && fin_flags[`SPFPU_FLG_DEN] |=>
      RES_DATA == `SPFPU_QNAN && float_status_register_q[`SPFPU_FLG_DEN])
    else $error("denormal operand did not give fixed NaN");
  a_ovf_inf: assert property (
    finish && fin_flags[`SPFPU_FLG_OVF] |=>
      RES_DATA[30:0] == `SPFPU_INF_MAG)
    else $error("overflow did not give infinity");
  a_unf_zero: assert property (
    finish && fin_flags[`SPFPU_FLG_UNF] |=> RES_DATA[30:0] == 31'h0)
    else $error("underflow did not flush to zero");
  a_nan_fixed: assert property (
    RES_VALID && RES_DATA[30:23] == `SPFPU_EXP_ALL1 &&
    RES_DATA[22:0] != 23'h0 &&
    !(op_q inside {[compare_less_op:compare_unordered_op], op_fint})
    |-> RES_DATA == `SPFPU_QNAN)
    else $error("NaN result not the fixed pattern");

endmodule // spfpu_top

/* File: verif/spfpu_issuer.sv */
// Model of the processor stage that issues operations
`timescale 1ns/1ps
module spfpu_issuer import spfpu_pkg::*; (
  input wire logic SYS_CLK,
  output logic OP_VALID,
  output logic [3:0] OP_CODE,
  output logic [31:0] OP_A,
  output logic [31:0] OP_B,
  output logic [4:0] OP_DEST
);
  initial begin
    OP_VALID = 1'b0;
    OP_CODE = 4'h0;
    OP_A = 32'h0;
    OP_B = 32'h0;
    OP_DEST = 5'h0;
  end
  // Caller waits for the result first, so the first edge always takes
  task automatic issue(input logic [3:0] c, input logic [31:0] a, b);
    @(posedge SYS_CLK);
    OP_VALID <= 1'b1;
    OP_CODE <= c;
    OP_A <= a;
    OP_B <= b;
    OP_DEST <= {1'b0, c};
    @(posedge SYS_CLK);
    OP_VALID <= 1'b0;
    // Released operands show no stale value
    OP_A <= ~a;
    OP_B <= ~b;
  endtask
endmodule // spfpu_issuer

/* File: verif/test_single_precision_fpu.sv */
// Self-checking bench of the floating point unit
`timescale 1ns/1ps
module test_single_precision_fpu import spfpu_pkg::*; ;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic OP_VALID, BUSY, RES_VALID, RES_WE, FP_EXC, IRQ, REG_WR, REG_RD;
  logic [3:0] OP_CODE, REG_ADDR;
  logic [31:0] OP_A, OP_B, RES_DATA, REG_WDATA, REG_RDATA;
  logic [4:0] OP_DEST, RES_DEST;
  logic [38:0] exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int busy_n;
  int seed = 39681;
  always #10 SYS_CLK = ~SYS_CLK;
  spfpu_top spfpu_top_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_A(OP_A), .OP_B(OP_B),
    .OP_DEST(OP_DEST), .BUSY(BUSY), .RES_VALID(RES_VALID),
    .RES_WE(RES_WE), .RES_DEST(RES_DEST), .RES_DATA(RES_DATA),
    .FP_EXC(FP_EXC), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
  spfpu_issuer spfpu_issuer_inst (.SYS_CLK(SYS_CLK), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .OP_A(OP_A), .OP_B(OP_B), .OP_DEST(OP_DEST));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [38:0] got, input logic [38:0] want);
    cmp_count++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // Expected note is {dest, data, write enable, exception}
  task automatic run(input logic [3:0] c, input logic [31:0] a, b, r,
                     input logic [1:0] fl);
    exp_q.push_back({1'b0, c, r, fl});
    spfpu_issuer_inst.issue(c, a, b);
    busy_n = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge SYS_CLK);
      if (RES_VALID === 1'b1) return;
      busy_n += (BUSY === 1'b1);
    end
    n_errors++;
    end_of_test();
  endtask
  always @(posedge SYS_CLK) begin
    if (RES_VALID === 1'b1) begin
      chk({RES_DEST, RES_DATA, RES_WE, FP_EXC},
          exp_q.size() > 0 ? exp_q.pop_front() : 39'h0);
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(posedge SYS_CLK);
    chk({7'h0, REG_RDATA}, {7'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int a;
    int b;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 32'h0;
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'hc, 32'h0);
    run(op_add, 32'h3f800000, 32'h40000000, 32'h40400000, 2'b10);
    chk(39'(busy_n), 39'h1);
    run(op_sub, 32'h3f800000, 32'h40000000, 32'hbf800000, 2'b10);
    run(op_mul, 32'h40000000, 32'h40400000, 32'h40c00000, 2'b10);
    run(op_div, 32'h40c00000, 32'h40400000, 32'h40000000, 2'b10);
    chk(39'(busy_n), 39'h1d);
    run(op_add, 32'h3f800000, 32'h33800000, 32'h3f800000, 2'b10);
    run(op_add, 32'h3f800001, 32'h33800000, 32'h3f800002, 2'b10);
    run(op_add, 32'h80000000, 32'h80000000, 32'h80000000, 2'b10);
    run(op_add, 32'h7f800000, 32'h3f800000, 32'h7f800000, 2'b10);
    run(op_add, 32'h7fc00000, 32'h3f800000, 32'hffc00000, 2'b10);
    run(op_mul, 32'h7f7fffff, 32'h40000000, 32'h7f800000, 2'b10);
    run(op_mul, 32'h80800000, 32'h3f000000, 32'h80000000, 2'b10);
    run(op_sqrt, 32'h40800000, 32'h0, 32'h40000000, 2'b10);
    run(op_flt, 32'hfffffffd, 32'h0, 32'hc0400000, 2'b10);
    run(op_fint, 32'hc0400000, 32'h0, 32'hfffffffd, 2'b10);
    for (int i = 0; i < 7; i++) begin
      run(4'(compare_less_op + i), 32'h3f800000, 32'h40000000,
          32'((7'h15 >> i) & 7'h01), 2'b10);
    end
    run(compare_unordered_op, 32'h7fc00001, 32'h0, 32'h1, 2'b10);
    $display("test arithmetic done");
    for (int i = 0; i < 6; i++) begin
      a = $random(seed) % 1000;
      b = $random(seed) % 1000;
      run(op_add, $shortrealtobits(shortreal'(a)),
          $shortrealtobits(shortreal'(b)),
          $shortrealtobits(shortreal'(a + b)), 2'b10);
    end
    $display("test random done");
    wr(4'h0, 32'h1);
    run(op_mul, 32'h00000001, 32'h3f800000, 32'hffc00000, 2'b01);
    run(op_div, 32'h3f800000, 32'h0, 32'h7f800000, 2'b01);
    run(4'he, 32'h3f800000, 32'h0, 32'hffc00000, 2'b01);
    chk({38'h0, IRQ}, 39'h0);
    wr(4'h8, 32'h1f);
    // Mask lands at the strobe edge, the registered level one edge later
    repeat (2) @(posedge SYS_CLK);
    chk({38'h0, IRQ}, 39'h1);
    rd(4'h4, 32'h1f);
    @(posedge SYS_CLK);
    chk({38'h0, IRQ}, 39'h0);
    wr(4'h4, 32'h1f);
    rd(4'h4, 32'h0);
    $display("test exceptions done");
    end_of_test();
  end
endmodule // test_single_precision_fpu
